//--- logic/ecs_pkg.sv
// Package for the exception control and state register block.
// Assumes a single 50 MHz core clock and a synchronous active-high reset.
package ecs_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] ECS_OFF_CTRL_STATE = 16'hED04;
    localparam logic [15:0] ECS_OFF_VECTOR_BASE = 16'hED08;
    localparam logic [15:0] ECS_OFF_RESET_CTRL = 16'hED0C;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ECS_BIT_NMI_SET = 31;
    localparam int ECS_BIT_DEFER_SET = 28;
    localparam int ECS_BIT_DEFER_CLR = 27;
    localparam int ECS_BIT_TICK_SET = 26;
    localparam int ECS_BIT_TICK_CLR = 25;
    localparam int ECS_BIT_PREEMPT = 23;
    localparam int ECS_BIT_EXT_PEND = 22;
    localparam int ECS_TOP_PEND_LSB = 12;
    localparam int ECS_VBASE_LSB = 8;
    localparam int ECS_KEY_LSB = 16;
    localparam int ECS_BIT_BYTE_ORDER = 15;
    localparam int ECS_BIT_SYSRST = 2;
    localparam int ECS_BIT_CLR_ACTIVE = 1;
    localparam int ECS_EXC_W = 9;
    localparam int ECS_VBASE_W = 24;
    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [15:0] ECS_WRITE_KEY = 16'h05FA;
    localparam logic [23:0] ECS_VBASE_RESET = 24'h000000;
    localparam logic [8:0] ECS_EXC_NONE = 9'h000;
    localparam logic ECS_LITTLE_ENDIAN = 1'b0;
endpackage

//--- logic/ecs_if.sv
// Interface joining the register block and the core-side exception logic.
// Assumes both ends run on the same SYS_CLK.
`timescale 1ns/1ps
interface ecs_if;
    logic nmi_pending;
    logic nmi_taken;
    logic nmi_raise;
    logic defer_pending;
    logic defer_taken;
    logic tick_pending;
    logic tick_taken;
    logic tick_raise;
    logic [8:0] top_pending_exception_number;
    logic [8:0] active_exception_number;
    logic external_irq_pending;
    logic interrupt_will_preempt;
    logic core_halted;
    logic debug_interrupt_mask;
    logic clear_all_active_state;
    logic system_reset_request;

    modport regs (
        output nmi_pending, output defer_pending, output tick_pending,
        output clear_all_active_state, output system_reset_request,
        input nmi_taken, input nmi_raise, input defer_taken, input tick_taken,
        input tick_raise, input top_pending_exception_number,
        input active_exception_number, input external_irq_pending,
        input interrupt_will_preempt, input core_halted, input debug_interrupt_mask
    );
    modport core (
        input nmi_pending, input defer_pending, input tick_pending,
        input clear_all_active_state, input system_reset_request,
        output nmi_taken, output nmi_raise, output defer_taken, output tick_taken,
        output tick_raise, output top_pending_exception_number,
        output active_exception_number, output external_irq_pending,
        output interrupt_will_preempt, output core_halted, output debug_interrupt_mask
    );
endinterface

//--- logic/ecs_regs.sv
// Exception control/state, vector base and keyed reset-control registers.
// Assumes software access over a plain strobe port, read data one cycle later.
//
// Operation
// (RL1) Write 1 bit 31 pends non-maskable
// (RL2) Non-maskable handler entered on detected set; code enters it only once no handler is active and the core is not halted
// (RL3) Handler entry clears non-maskable pending bit
// (RL4) Write 1 bit 28 pends deferred call
// (RL5) Write 1 bit 27 clears deferred call
// (RL6) Write 1 bit 26 pends tick
// (RL7) Write 1 bit 25 clears tick; write-only
// (RL8) Bit 23 preempt flag, only while halted
// (RL9) Bit 22 reports external interrupt pending
// (RL10) Field 20:12 top pending number, zero none
// (RL11) Top pending ignores primary interrupt mask
// (RL12) Field 8:0 active number, reset zero
// (RL13) Vector base bits 31:8, reset zero
// (RL14) Reset-control writes need key 0x05FA
// (RL15) Bit 15 reads zero, little-endian
// (RL16) Keyed bit 2 asserts system reset request
// (RL17) Outer system resets all but debug; here RST also clears the debug halt flag in ecs_core
// (RL18) Requested reset clears debug halt flag
// (RL19) Bit 1 self-clears, debugger while halted
// (RL20) Clear-active wipes active state, thread mode
// (RL21) Debugger reinitialises stack after clear-active
// (RL22) Reserved bits read zero, writes ignored
// (RL23) Set and clear together means clear
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module ecs_regs
    import ecs_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [15:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic DEBUG_ACCESS,
    output logic [31:0] RDATA,
    output logic [23:0] VECTOR_BASE,
    ecs_if.regs LINK
);
    import ecs_pkg::*;

    logic wr_state;
    logic wr_vbase;
    logic wr_rst;
    logic key_ok;
    logic nmi_pend;
    logic defer_pend;
    logic tick_pend;
    logic sysrst;
    logic clr_active;
    logic [23:0] vbase;
    logic [31:0] next_rdata;
    logic [31:0] state_word;
    logic [31:0] vbase_word;
    logic [31:0] reset_word;

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    assign wr_state = WR && (ADDR == ECS_OFF_CTRL_STATE);
    assign wr_vbase = WR && (ADDR == ECS_OFF_VECTOR_BASE);
    assign wr_rst = WR && (ADDR == ECS_OFF_RESET_CTRL);
    assign key_ok = WDATA[31:ECS_KEY_LSB] == ECS_WRITE_KEY; // RL14

    // ------------------------------------------------------------
    // Pending flags
    // ------------------------------------------------------------
    // Software or hardware set wins over handler-entry clear
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            nmi_pend <= 1'b0;
        end else if ((wr_state && WDATA[ECS_BIT_NMI_SET]) || LINK.nmi_raise) begin
            nmi_pend <= 1'b1; // RL1 RL3
        end else if (LINK.nmi_taken) begin
            nmi_pend <= 1'b0; // RL3
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            defer_pend <= 1'b0;
        end else if (wr_state && WDATA[ECS_BIT_DEFER_CLR]) begin
            defer_pend <= 1'b0; // RL5 RL23
        end else if (wr_state && WDATA[ECS_BIT_DEFER_SET]) begin
            defer_pend <= 1'b1; // RL4
        end else if (LINK.defer_taken) begin
            defer_pend <= 1'b0;
        end
    end

    // Timer event beats a clear written in the same cycle, so no tick is lost
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            tick_pend <= 1'b0;
        end else if (LINK.tick_raise) begin
            tick_pend <= 1'b1; // RL6
        end else if (wr_state && WDATA[ECS_BIT_TICK_CLR]) begin
            tick_pend <= 1'b0; // RL7 RL23
        end else if (wr_state && WDATA[ECS_BIT_TICK_SET]) begin
            tick_pend <= 1'b1; // RL6
        end else if (LINK.tick_taken) begin
            tick_pend <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Vector base and reset control
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            vbase <= ECS_VBASE_RESET;
        end else if (wr_vbase) begin
            vbase <= WDATA[31:ECS_VBASE_LSB]; // RL13
        end
    end

    // Request held until the outer reset arrives and clears it
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            sysrst <= 1'b0;
        end else if (wr_rst && key_ok && WDATA[ECS_BIT_SYSRST]) begin
            sysrst <= 1'b1; // RL16 RL14
        end
    end

    // One-cycle pulse; only a halted-core debugger write counts
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            clr_active <= 1'b0;
        end else begin
            clr_active <= wr_rst && key_ok && WDATA[ECS_BIT_CLR_ACTIVE]
                && DEBUG_ACCESS && LINK.core_halted; // RL19 RL20
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Tick clear bit is write-only and reads zero
    always_comb begin
        state_word = 32'h00000000; // RL22
        state_word[ECS_BIT_NMI_SET] = nmi_pend; // RL1
        state_word[ECS_BIT_DEFER_SET] = defer_pend; // RL4
        state_word[ECS_BIT_TICK_SET] = tick_pend; // RL6
        state_word[ECS_BIT_PREEMPT] = LINK.core_halted
            && LINK.interrupt_will_preempt; // RL8
        state_word[ECS_BIT_EXT_PEND] = LINK.external_irq_pending; // RL9
        state_word[ECS_TOP_PEND_LSB +: ECS_EXC_W] =
            LINK.top_pending_exception_number; // RL10 RL11
        state_word[ECS_EXC_W-1:0] = LINK.active_exception_number; // RL12
    end

    always_comb begin
        vbase_word = 32'h00000000; // RL22
        vbase_word[31:ECS_VBASE_LSB] = vbase; // RL13
    end

    // Key field reads zero; byte order fixed little-endian
    always_comb begin
        reset_word = 32'h00000000; // RL22
        reset_word[ECS_BIT_BYTE_ORDER] = ECS_LITTLE_ENDIAN; // RL15
        reset_word[ECS_BIT_SYSRST] = sysrst; // RL16
    end

    // Unmapped offsets and idle cycles return zero
    always_comb begin
        next_rdata = 32'h00000000;
        if (RD) begin
            case (ADDR)
                ECS_OFF_CTRL_STATE: begin
                    next_rdata = state_word;
                end
                ECS_OFF_VECTOR_BASE: begin
                    next_rdata = vbase_word;
                end
                ECS_OFF_RESET_CTRL: begin
                    next_rdata = reset_word;
                end
                default: begin
                    next_rdata = 32'h00000000; // RL22
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            RDATA <= 32'h00000000;
        end else begin
            RDATA <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Outputs toward the core side
    // ------------------------------------------------------------
    assign VECTOR_BASE = vbase;
    assign LINK.nmi_pending = nmi_pend; // RL2
    assign LINK.defer_pending = defer_pend;
    assign LINK.tick_pending = tick_pend;
    assign LINK.system_reset_request = sysrst;
    assign LINK.clear_all_active_state = clr_active;
endmodule

//--- logic/ecs_core.sv
// Core-side exception state: takes pends, tracks active and top pending.
// Assumes the outer reset controller drives RST from the reset request.
`timescale 1ns/1ps
module ecs_core
    import ecs_pkg::*;
#(
    parameter int IRQ_W = 32
)
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [IRQ_W-1:0] IRQ_PENDING,
    input wire logic [IRQ_W-1:0] IRQ_ENABLE,
    input wire logic PRIMARY_MASK,
    input wire logic NMI_IN,
    input wire logic TICK_EVENT,
    input wire logic HALT_REQ,
    input wire logic DEBUG_MASK,
    input wire logic HANDLER_DONE,
    output logic HALTED,
    output logic THREAD_MODE,
    output logic [8:0] STATUS_EXC_NUMBER,
    ecs_if.core LINK
);
    import ecs_pkg::*;

    if (IRQ_W < 1 || IRQ_W > 32) begin
        $error("IRQ_W out of range");
    end

    logic halted;
    logic [8:0] active;
    logic [8:0] top;
    logic [IRQ_W-1:0] live;
    logic take;

    assign live = IRQ_PENDING & IRQ_ENABLE; // RL11

    // Primary mask deliberately not applied to the top pending number
    always_comb begin
        top = ECS_EXC_NONE;
        for (int i = IRQ_W - 1; i >= 0; i--) begin
            if (live[i]) begin
                top = 9'(16 + i);
            end
        end
        if (LINK.tick_pending) top = 9'h00F;
        if (LINK.defer_pending) top = 9'h00E;
        if (LINK.nmi_pending) top = 9'h002;
    end

    assign take = !halted && (active == ECS_EXC_NONE) && (top != ECS_EXC_NONE)
        && (top == 9'h002 || !PRIMARY_MASK); // RL2

    // Reset request answered by the outer reset; halt flag cleared by it
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            halted <= 1'b0; // RL18
        end else if (HALT_REQ) begin
            halted <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            active <= ECS_EXC_NONE;
        end else if (LINK.clear_all_active_state) begin
            active <= ECS_EXC_NONE; // RL20
        end else if (take) begin
            active <= top;
        end else if (HANDLER_DONE) begin
            active <= ECS_EXC_NONE;
        end
    end

    assign LINK.nmi_taken = take && top == 9'h002;
    assign LINK.defer_taken = take && top == 9'h00E;
    assign LINK.tick_taken = take && top == 9'h00F;
    assign LINK.nmi_raise = NMI_IN;
    assign LINK.tick_raise = TICK_EVENT;
    assign LINK.top_pending_exception_number = top;
    assign LINK.active_exception_number = active;
    assign LINK.external_irq_pending = |IRQ_PENDING;
    assign LINK.interrupt_will_preempt = top != ECS_EXC_NONE && !DEBUG_MASK;
    assign LINK.core_halted = halted;
    assign LINK.debug_interrupt_mask = DEBUG_MASK;
    assign HALTED = halted;
    assign THREAD_MODE = active == ECS_EXC_NONE;
    assign STATUS_EXC_NUMBER = active;
endmodule

//--- tb/ecs_props.sv
// Checker for the link between the register block and the core side.
// Assumes one clock domain and the synchronous reset of the bench.
`timescale 1ns/1ps
module ecs_props (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic nmi_pending,
    input wire logic nmi_taken,
    input wire logic nmi_raise,
    input wire logic defer_pending,
    input wire logic tick_pending,
    input wire logic [8:0] top_pending_exception_number,
    input wire logic [8:0] active_exception_number,
    input wire logic external_irq_pending,
    input wire logic core_halted,
    input wire logic clear_all_active_state,
    input wire logic system_reset_request
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);
    // ----------------------------------------
    // Pending flags
    // ----------------------------------------
    chk_nmi_raise_pends: assert property (nmi_raise |=> nmi_pending)
        else $error("nmi raise not pending");
    chk_nmi_take_clears: assert property (nmi_taken && !nmi_raise |=> !nmi_pending)
        else $error("nmi entry left pending");
    // Already in the handler a new pend must wait
    chk_nmi_prompt: assert property ($rose(nmi_pending) && !core_halted
        && active_exception_number != 9'h002 |-> ##[0:4] nmi_taken)
        else $error("nmi not entered promptly");
    chk_top_none: assert property (!(nmi_pending || defer_pending || tick_pending
        || external_irq_pending) |-> top_pending_exception_number == 9'h000)
        else $error("top pending not zero");
    chk_nmi_top: assert property (nmi_pending |-> top_pending_exception_number == 9'h002)
        else $error("nmi not top pending");
    chk_defer_top: assert property (defer_pending && !nmi_pending
        |-> top_pending_exception_number == 9'h00E)
        else $error("deferred call not top");
    // ----------------------------------------
    // Debug clear and reset request
    // ----------------------------------------
    chk_clr_pulse: assert property (clear_all_active_state |=> !clear_all_active_state)
        else $error("clear-active not one cycle");
    chk_clr_halted: assert property (clear_all_active_state |-> $past(core_halted))
        else $error("clear-active while running");
    chk_clr_wipes: assert property (clear_all_active_state
        |-> ##[1:2] active_exception_number == 9'h000)
        else $error("active state survived clear");
    chk_rst_req_holds: assert property (system_reset_request |=> system_reset_request)
        else $error("reset request dropped early");
    cov_nmi: cover property (nmi_taken);
    cov_clr: cover property (clear_all_active_state);
    cov_req: cover property (system_reset_request);
endmodule

//--- tb/exception_control_state_regs_tb.sv
// Bench for the register block facing its core-side partner.
// Assumes ecs_pkg, ecs_if and both design modules compile first.
`timescale 1ns/1ps
module exception_control_state_regs_tb;
    import ecs_pkg::*;
    logic clk, rst_init, rst_req, rst, wr, rd, dbg, pmask, nmi_in, tick_ev, halt_req, done;
    logic halted, thread, defer, tick, dmask;
    logic [15:0] addr;
    logic [31:0] wdata, rdata, r, w;
    logic [23:0] vbase;
    logic [7:0] irq_p, irq_e;
    logic [8:0] status;
    logic [15:0] offs [4] = '{16'hED04, 16'hED08, 16'hED0C, 16'hED10};
    int miscompares, num_checks;
    ecs_if link();
    ecs_regs u_ecs_regs(.SYS_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .DEBUG_ACCESS(dbg), .RDATA(rdata), .VECTOR_BASE(vbase), .LINK(link.regs));
    ecs_core #(.IRQ_W(8)) u_ecs_core(.SYS_CLK(clk), .RST(rst), .IRQ_PENDING(irq_p),
        .IRQ_ENABLE(irq_e), .PRIMARY_MASK(pmask), .NMI_IN(nmi_in), .TICK_EVENT(tick_ev),
        .HALT_REQ(halt_req), .DEBUG_MASK(dmask), .HANDLER_DONE(done), .HALTED(halted),
        .THREAD_MODE(thread), .STATUS_EXC_NUMBER(status), .LINK(link.core));
    ecs_props u_ecs_props(.SYS_CLK(clk), .RST(rst), .nmi_pending(link.nmi_pending),
        .nmi_taken(link.nmi_taken), .nmi_raise(link.nmi_raise),
        .defer_pending(link.defer_pending), .tick_pending(link.tick_pending),
        .top_pending_exception_number(link.top_pending_exception_number),
        .active_exception_number(link.active_exception_number),
        .external_irq_pending(link.external_irq_pending), .core_halted(link.core_halted),
        .clear_all_active_state(link.clear_all_active_state),
        .system_reset_request(link.system_reset_request));
    // Outer system turns a request into a reset of everything here
    always_ff @(posedge clk) rst_req <= link.system_reset_request;
    assign rst = rst_init | rst_req;
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [15:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        r = rdata;
    endtask
    task automatic pulse_done;
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    function automatic logic [31:0] exp_interrupt_control_state(input logic dp, input logic tp);
        logic [8:0] top;
        top = dp ? 9'h00E : (tp ? 9'h00F : 9'h000);
        return {3'h0, dp, 1'b0, tp, 5'h00, top, 12'h000};
    endfunction
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #200us;
        miscompares++;
        report_and_stop();
    end
    initial begin
        {wr, rd, dbg, pmask, nmi_in, tick_ev, halt_req, done, rst_init} = 9'h001;
        {addr, wdata, irq_p, irq_e, dmask} = '0;
        miscompares = 0;
        num_checks = 0;
        void'($urandom(74852));
        repeat (5) @(posedge clk);
        rst_init <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rreg(offs[i]);
            check(r, 32'h0);
        end
        $display("test reset values done");
        repeat (4) begin
            w = $urandom;
            wreg(16'hED08, w);
            rreg(16'hED08);
            check(r, {w[31:8], 8'h00});
            check({8'h00, vbase}, {8'h00, w[31:8]});
        end
        $display("test vector base done");
        wreg(16'hED04, 32'h80000000);
        repeat (4) @(posedge clk);
        rreg(16'hED04);
        check(r & 32'h801FF1FF, 32'h00000002);
        nmi_in <= 1'b1;
        @(posedge clk);
        nmi_in <= 1'b0;
        rreg(16'hED04);
        check(r & 32'h801FF1FF, 32'h80002002);
        pulse_done();
        rreg(16'hED04);
        check(r & 32'h801FF1FF, 32'h00000002);
        $display("test nmi done");
        // Halted so that pends stay visible instead of being taken
        halt_req <= 1'b1;
        defer = 1'b0;
        tick = 1'b0;
        repeat (16) begin
            w = $urandom & 32'h7FFFFFFF;
            wreg(16'hED04, w);
            if (w[28]) defer = 1'b1;
            if (w[27]) defer = 1'b0;
            if (w[26]) tick = 1'b1;
            if (w[25]) tick = 1'b0;
            rreg(16'hED04);
            check(r & 32'hF57FFE00, exp_interrupt_control_state(defer, tick));
        end
        // Corner: both set, then set and clear of both in one write
        wreg(16'hED04, 32'h14000000);
        wreg(16'hED04, 32'h1E000000);
        defer = 1'b0;
        rreg(16'hED04);
        check(r & 32'hF57FFE00, exp_interrupt_control_state(1'b0, 1'b0));
        tick_ev <= 1'b1;
        @(posedge clk);
        tick_ev <= 1'b0;
        rreg(16'hED04);
        check(r & 32'hF57FFE00, exp_interrupt_control_state(defer, 1'b1));
        wreg(16'hED04, 32'h0A000000);
        rreg(16'hED04);
        check(r & 32'hF57FFE00, 32'h0);
        $display("test pend flags done");
        pmask <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            w = $urandom;
            irq_p <= 8'h01 << i;
            irq_e <= {7'h00, w[0]} << i;
            dmask <= w[1];
            rreg(16'hED04);
            check({23'h0, r[20:12]}, w[0] ? 32'h10 + i : 32'h0);
            check({31'h0, r[22]}, 32'h1);
            check({31'h0, r[23]}, {31'h0, w[0] & ~w[1]});
        end
        irq_p <= 8'h00;
        $display("test external done");
        dbg <= 1'b1;
        wreg(16'hED0C, 32'h05FB0002);
        dbg <= 1'b0;
        wreg(16'hED0C, 32'h05FA0002);
        rreg(16'hED04);
        check({23'h0, r[8:0]}, 32'h2);
        dbg <= 1'b1;
        wreg(16'hED0C, 32'h05FA0002);
        dbg <= 1'b0;
        repeat (2) @(posedge clk);
        rreg(16'hED04);
        check({23'h0, r[8:0]}, 32'h0);
        check({22'h0, thread, status}, 32'h200);
        $display("test clear active done");
        // Core resumes only through reset, so a stale stack never runs
        halt_req <= 1'b0;
        wreg(16'hED0C, 32'h00000004);
        rreg(16'hED0C);
        check(r, 32'h0);
        wreg(16'hED0C, 32'h05FA0004);
        #1;
        check({31'h0, link.system_reset_request}, 32'h1);
        repeat (4) @(posedge clk);
        check({31'h0, halted}, 32'h0);
        // Second request with a handler active proves reset clears it
        wreg(16'hED04, 32'h80000000);
        repeat (2) @(posedge clk);
        rreg(16'hED04);
        check(r & 32'h801FF1FF, 32'h00000002);
        wreg(16'hED0C, 32'h05FA0004);
        repeat (4) @(posedge clk);
        rreg(16'hED04);
        check(r, 32'h0);
        $display("test reset request done");
        report_and_stop();
    end
endmodule
